/* hw/ffc_pkg.sv */
// Constants shared by the FIFO framing control register block.
// Functional notes
// - Near-full flag set when free FIFO space is at or below the threshold.
// - Near-empty flag set when FIFO byte count is at or below the threshold.
// - Threshold is six bits read/write, upper two bits reserved, reset 08h.
// - Writing 1 to control bit 7 stops the timer at once; reads 0.
// - Writing 1 to control bit 6 starts the timer at once; reads 0.
// - Identifier copy bit pushes ten stored bytes into the FIFO, then clears.
// - Control bit 4 selects initiator when 1, target when 0.
// - Control bits 2..0 show valid bits of last received byte; 0 means all.
// - Writing 1 to framing bit 7 begins transmission only while transceive waits for it.
// - Receive alignment picks the bit slot of the first received bit.
// - With alignment 7 the second bit lands in bit 0 of the next byte.
// - Transmit last-bits sets bits sent of final byte; 0 sends all.
// - Control and framing registers reset to 00h; bit 3 reserved in both.
// - FIFO holds 64 bytes; count rises on data writes, falls on reads.
// - Modem state reads 001 while transceive waits for transmit start.
package ffc_pkg;
    localparam logic [5:0] OFF_STATUS1 = 6'h07;
    localparam logic [5:0] OFF_STATUS2 = 6'h08;
    localparam logic [5:0] OFF_FIFO_DATA = 6'h09;
    localparam logic [5:0] OFF_FIFO_LEVEL = 6'h0a;
    localparam logic [5:0] OFF_WARN = 6'h0b;
    localparam logic [5:0] OFF_CTRL = 6'h0c;
    localparam logic [5:0] OFF_FRAMING = 6'h0d;
    localparam logic [5:0] WARN_RESET = 6'h08;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] FRAMING_RESET = 8'h00;
    localparam int CTRL_STOP_BIT = 7;
    localparam int CTRL_START_BIT = 6;
    localparam int CTRL_IDCOPY_BIT = 5;
    localparam int CTRL_INIT_BIT = 4;
    localparam int LEVEL_FLUSH_BIT = 7;
    localparam int FRM_SEND_BIT = 7;
    localparam int FRM_ALIGN_LSB = 4;
    localparam int STAT_HI_BIT = 1;
    localparam int STAT_LO_BIT = 0;
    localparam int FIFO_DEPTH = 64;
    localparam int ID_LEN = 10;
    localparam logic [2:0] MODEM_IDLE = 3'h0;
    localparam logic [2:0] MODEM_WAIT_SEND = 3'h1;
    localparam logic [2:0] MODEM_SENDING = 3'h3;
    typedef enum {FFC_IDLE, FFC_WAIT, FFC_SEND} ffc_modem_t;
endpackage

/* hw/ffc_regs.sv */
// Warning threshold, misc control and bit framing registers with their logic.
`timescale 1ns/1ps
`default_nettype none
module ffc_regs import ffc_pkg::*; #(
    parameter int FifoDepth = FIFO_DEPTH,
    parameter int IdLen = ID_LEN
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [5:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire logic transceiveActive,
    input wire logic rxFrameStart,
    input wire logic rxBitValid,
    input wire logic rxBitIn,
    input wire logic rxFrameEnd,
    output logic rxBytePush,
    output logic [7:0] rxByte,
    output logic timerStartPulse,
    output logic timerStopPulse,
    output logic idCopyPush,
    output logic [3:0] idCopyIndex,
    output logic initiatorMode,
    output logic [2:0] txFinalBitCount,
    output logic [2:0] modemState,
    output logic transmitStartPulse,
    output logic fifoFlushPulse,
    output logic fifoNearFullFlag,
    output logic fifoNearEmptyFlag,
    output logic [6:0] fifoFillCount
);
    logic [5:0] warnThreshold_r;
    logic [5:0] warnThreshold_nxt;
    logic [2:0] rx_first_bit_position_r;
    logic idCopyBusy_r;
    logic [2:0] rxFinalValidBits;
    logic [6:0] fillCount_nxt;
    ffc_modem_t modem_r;
    logic wrWarn;
    logic wrCtrl;
    logic wrFrm;
    logic wrData;
    logic rdData;
    logic flush;
    logic [3:0] copyRun_r;

    // Register port strobes.
    assign wrWarn = regWrEn && regAddr == OFF_WARN;
    assign wrCtrl = regWrEn && regAddr == OFF_CTRL;
    assign wrFrm = regWrEn && regAddr == OFF_FRAMING;
    assign wrData = regWrEn && regAddr == OFF_FIFO_DATA;
    assign rdData = regRdEn && regAddr == OFF_FIFO_DATA;
    assign flush = regWrEn && regAddr == OFF_FIFO_LEVEL
        && regWrData[LEVEL_FLUSH_BIT];

    ffc_rx_packer u_packer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .rx_first_bit_position(rx_first_bit_position_r),
        .frameStart(rxFrameStart),
        .bitValid(rxBitValid),
        .bitIn(rxBitIn),
        .frameEnd(rxFrameEnd),
        .bytePush(rxBytePush),
        .byteOut(rxByte),
        .lastBits(rxFinalValidBits)
    );

    // Threshold register; reserved upper bits are never stored.
    assign warnThreshold_nxt = wrWarn ? regWrData[5:0] : warnThreshold_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            warnThreshold_r <= WARN_RESET;
        end else begin
            warnThreshold_r <= warnThreshold_nxt;
        end
    end

    // Writable control and framing fields.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            initiatorMode <= CTRL_RESET[CTRL_INIT_BIT];
            rx_first_bit_position_r <= FRAMING_RESET[6:4];
            txFinalBitCount <= FRAMING_RESET[2:0];
        end else begin
            if (wrCtrl) begin
                initiatorMode <= regWrData[CTRL_INIT_BIT];
            end
            if (wrFrm) begin
                rx_first_bit_position_r <= regWrData[6:4];
                txFinalBitCount <= regWrData[2:0];
            end
        end
    end

    // Strobes last one cycle and are not stored, so they read back as 0.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timerStopPulse <= 1'b0;
            timerStartPulse <= 1'b0;
            fifoFlushPulse <= 1'b0;
        end else begin
            timerStopPulse <= wrCtrl && regWrData[CTRL_STOP_BIT];
            timerStartPulse <= wrCtrl && regWrData[CTRL_START_BIT];
            fifoFlushPulse <= flush;
        end
    end

    // Identifier copy sequencer; one byte per cycle, bit clears itself.
    // A new request during a copy is ignored so the FIFO never gets a
    // torn identifier.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            idCopyBusy_r <= 1'b0;
            idCopyPush <= 1'b0;
            idCopyIndex <= 4'h0;
        end else if (!idCopyBusy_r) begin
            idCopyPush <= 1'b0;
            idCopyIndex <= 4'h0;
            if (wrCtrl && regWrData[CTRL_IDCOPY_BIT]) begin
                idCopyBusy_r <= 1'b1;
            end
        end else if (idCopyPush && idCopyIndex == 4'(IdLen - 1)) begin
            idCopyPush <= 1'b0;
            idCopyBusy_r <= 1'b0;
        end else begin
            idCopyIndex <= idCopyPush ? idCopyIndex + 4'h1 : 4'h0;
            idCopyPush <= 1'b1;
        end
    end

    // Modem state: transceive waits here until the host sets transmit start.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            modem_r <= FFC_IDLE;
            transmitStartPulse <= 1'b0;
        end else begin
            transmitStartPulse <= 1'b0;
            unique case (modem_r)
                FFC_IDLE: begin
                    if (transceiveActive) begin
                        modem_r <= FFC_WAIT;
                    end
                end
                FFC_WAIT: begin
                    if (!transceiveActive) begin
                        modem_r <= FFC_IDLE;
                    end else if (wrFrm && regWrData[FRM_SEND_BIT]) begin
                        modem_r <= FFC_SEND;
                        transmitStartPulse <= 1'b1;
                    end
                end
                FFC_SEND: begin
                    // Further writes, of 0 or 1, leave the send running.
                    if (!transceiveActive) begin
                        modem_r <= FFC_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            modemState <= MODEM_IDLE;
        end else begin
            unique case (modem_r)
                FFC_IDLE: modemState <= MODEM_IDLE;
                FFC_WAIT: modemState <= MODEM_WAIT_SEND;
                FFC_SEND: modemState <= MODEM_SENDING;
            endcase
        end
    end

    // Fill count bookkeeping; it saturates so a misbehaving host cannot
    // wrap it, and flush wins over every push or pop in the same cycle.
    always_comb begin
        int cnt;
        cnt = int'(fifoFillCount);
        if (flush) begin
            cnt = 0;
        end else begin
            cnt = cnt + int'(wrData) + int'(idCopyPush)
                + int'(rxBytePush);
            if (rdData && fifoFillCount != 7'h00) begin
                cnt = cnt - 1;
            end
            if (cnt > FifoDepth) begin
                cnt = FifoDepth;
            end
        end
        fillCount_nxt = 7'(cnt);
    end

    // Flags come from the next count and threshold so they are never stale.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fifoFillCount <= 7'h00;
            fifoNearFullFlag <= 1'b0;
            fifoNearEmptyFlag <= 1'b1;
        end else begin
            fifoFillCount <= fillCount_nxt;
            fifoNearFullFlag <= (7'(FifoDepth) - fillCount_nxt)
                <= {1'b0, warnThreshold_nxt};
            fifoNearEmptyFlag <= fillCount_nxt
                <= {1'b0, warnThreshold_nxt};
        end
    end

    // Read port; reserved bits and strobes read 0, data port reads are
    // served by the FIFO outside.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            unique case (regAddr)
                OFF_STATUS1: regRdData <= {6'h00, fifoNearFullFlag,
                    fifoNearEmptyFlag};
                OFF_STATUS2: regRdData <= {5'h00, modemState};
                OFF_FIFO_LEVEL: regRdData <= {1'b0, fifoFillCount};
                OFF_WARN: regRdData <= {2'h0, warnThreshold_r};
                OFF_CTRL: regRdData <= {2'h0, idCopyBusy_r, initiatorMode,
                    1'b0, rxFinalValidBits};
                OFF_FRAMING: regRdData <= {1'b0, rx_first_bit_position_r, 1'b0,
                    txFinalBitCount};
                default: regRdData <= 8'h00;
            endcase
        end
    end

    nearEmpty_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        fifoNearEmptyFlag == (fifoFillCount <= {1'b0, warnThreshold_r}))
        else $error("Near-empty flag disagrees with count.");
    nearFull_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        fifoNearFullFlag
            == ((7'(FifoDepth) - fifoFillCount) <= {1'b0, warnThreshold_r}))
        else $error("Near-full flag disagrees with free space.");
    warnReset_a: assert property (@(posedge core_clk)
        !rst_n |=> warnThreshold_r == WARN_RESET || $rose(rst_n))
        else $error("Threshold not at reset value.");
    stopPulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrCtrl && regWrData[CTRL_STOP_BIT]) |=> timerStopPulse
            ##1 !timerStopPulse || $past(wrCtrl))
        else $error("Timer stop strobe wrong.");
    startPulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        timerStartPulse |-> $past(wrCtrl) && $past(regWrData[CTRL_START_BIT]))
        else $error("Timer start strobe without a write.");
    // Length of the current push run; a counter keeps the copy-length check
    // cheap where a long repetition would be unrolled by the tools.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            copyRun_r <= 4'h0;
        end else begin
            copyRun_r <= idCopyPush ? copyRun_r + 4'h1 : 4'h0;
        end
    end
    idCopyMax_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        idCopyPush |-> copyRun_r < 4'(IdLen))
        else $error("Identifier copy longer than ten bytes.");
    idCopyLen_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(idCopyPush) |-> copyRun_r == 4'(IdLen))
        else $error("Identifier copy not ten bytes.");
    waitCode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (modem_r == FFC_WAIT) |=> modemState == MODEM_WAIT_SEND)
        else $error("Modem state not 001 while waiting.");
    sendStart_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (modem_r == FFC_WAIT && transceiveActive && wrFrm
            && regWrData[FRM_SEND_BIT]) |=> transmitStartPulse
            ##1 modemState == MODEM_SENDING)
        else $error("Transmit start did not begin sending.");
    fillBound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrData && !rdData && !flush && fifoFillCount < 7'(FifoDepth - 2))
            |=> fifoFillCount > $past(fifoFillCount))
        else $error("Data write did not raise fill count.");
    ctrlRead_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (regRdEn && regAddr == OFF_CTRL) |=> regRdData[7:6] == 2'h0
            && regRdData[3] == 1'b0 && regRdData[4] == initiatorMode)
        else $error("Control read shows strobe or reserved bits.");
endmodule
`default_nettype wire

/* hw/ffc_rx_packer.sv */
// Places received bits into FIFO bytes starting at the programmed alignment.
`timescale 1ns/1ps
`default_nettype none
module ffc_rx_packer import ffc_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [2:0] rx_first_bit_position,
    input wire logic frameStart,
    input wire logic bitValid,
    input wire logic bitIn,
    input wire logic frameEnd,
    output logic bytePush,
    output logic [7:0] byteOut,
    output logic [2:0] lastBits
);
    logic [7:0] shift_r;
    logic [2:0] pos_r;

    // Each bit goes to the current slot; a full byte is pushed at slot 7.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= 8'h00;
            pos_r <= 3'h0;
            bytePush <= 1'b0;
            byteOut <= 8'h00;
        end else begin
            bytePush <= 1'b0;
            if (frameStart) begin
                shift_r <= 8'h00;
                pos_r <= rx_first_bit_position;
            end else if (bitValid) begin
                if (pos_r == 3'h7) begin
                    byteOut <= {bitIn, shift_r[6:0]};
                    bytePush <= 1'b1;
                    shift_r <= 8'h00;
                    pos_r <= 3'h0;
                end else begin
                    shift_r[pos_r] <= bitIn;
                    pos_r <= pos_r + 3'h1;
                end
            end else if (frameEnd && pos_r != 3'h0) begin
                // A partial tail byte is still delivered to the FIFO.
                byteOut <= shift_r;
                bytePush <= 1'b1;
            end
        end
    end

    // Valid-bit count of the last byte; zero when the frame ended on a byte.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lastBits <= 3'h0;
        end else if (frameEnd && !frameStart && !bitValid) begin
            lastBits <= pos_r;
        end
    end

    wrapNext_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bitValid && !frameStart && pos_r == 3'h7) |=> bytePush && pos_r == 3'h0)
        else $error("Bit in slot 7 did not close the byte.");
    alignLoad_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        frameStart |=> pos_r == $past(rx_first_bit_position))
        else $error("First bit slot not taken from alignment.");
endmodule
`default_nettype wire

/* testbench/ffc_host_model.sv */
// Host model that drives the register port and the transceive command.
`timescale 1ns/1ps
`default_nettype none
module ffc_host_model (
    input wire logic core_clk,
    input wire logic [7:0] regRdData,
    output var logic [5:0] regAddr,
    output var logic regWrEn,
    output var logic regRdEn,
    output var logic [7:0] regWrData,
    output var logic transceiveActive
);
    // Bus idles; alignment stays zero except for bit-oriented frames.
    initial begin
        regAddr = 6'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regWrData = 8'h00;
        transceiveActive = 1'b0;
    end

    // One write per call; data flips afterwards so a stale byte never matches.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge core_clk);
        regWrEn = 1'b0;
        regWrData = ~d;
    endtask

    // Read data is registered, so it is taken one cycle after the request.
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge core_clk);
        regRdEn = 1'b0;
        d = regRdData;
    endtask

    // The transmit start strobe is meant for use while this level is high.
    task automatic transceive(input logic on);
        @(negedge core_clk);
        transceiveActive = on;
    endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the FIFO framing control register block.
`timescale 1ns/1ps
`default_nettype none
module testbench import ffc_pkg::*; ;
    logic core_clk, rst_n, regWrEn, regRdEn, transceiveActive;
    logic rxFrameStart, rxBitValid, rxBitIn, rxFrameEnd, rxBytePush;
    logic [5:0] regAddr;
    logic [7:0] regWrData, regRdData, rxByte;
    logic timerStartPulse, timerStopPulse, idCopyPush, initiatorMode;
    logic transmitStartPulse, fifoFlushPulse;
    logic fifoNearFullFlag, fifoNearEmptyFlag;
    logic [3:0] idCopyIndex;
    logic [2:0] txFinalBitCount, modemState;
    logic [6:0] fifoFillCount;
    logic [7:0] cntStart = 8'h00, cntStop = 8'h00, cntTx = 8'h00;
    logic [7:0] cntCopy = 8'h00, cntFlush = 8'h00, idxBad = 8'h00;
    logic [7:0] rxQ[$];
    int numErrors = 0;
    int compares = 0;

    ffc_host_model host (.core_clk(core_clk), .regRdData(regRdData),
        .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regWrData(regWrData), .transceiveActive(transceiveActive));

    ffc_regs #(.FifoDepth(FIFO_DEPTH), .IdLen(ID_LEN)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
        .regRdData(regRdData), .transceiveActive(transceiveActive),
        .rxFrameStart(rxFrameStart), .rxBitValid(rxBitValid),
        .rxBitIn(rxBitIn), .rxFrameEnd(rxFrameEnd),
        .rxBytePush(rxBytePush), .rxByte(rxByte),
        .timerStartPulse(timerStartPulse), .timerStopPulse(timerStopPulse),
        .idCopyPush(idCopyPush), .idCopyIndex(idCopyIndex),
        .initiatorMode(initiatorMode), .txFinalBitCount(txFinalBitCount),
        .modemState(modemState), .transmitStartPulse(transmitStartPulse),
        .fifoFlushPulse(fifoFlushPulse), .fifoNearFullFlag(fifoNearFullFlag),
        .fifoNearEmptyFlag(fifoNearEmptyFlag), .fifoFillCount(fifoFillCount));

    // Free-running 25 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Pulses are counted rather than caught, so their exact cycle may vary.
    always @(posedge core_clk) begin
        cntStart <= cntStart + {7'h00, timerStartPulse === 1'b1};
        cntStop <= cntStop + {7'h00, timerStopPulse === 1'b1};
        cntTx <= cntTx + {7'h00, transmitStartPulse === 1'b1};
        cntCopy <= cntCopy + {7'h00, idCopyPush === 1'b1};
        cntFlush <= cntFlush + {7'h00, fifoFlushPulse === 1'b1};
        if (idCopyPush === 1'b1 && idCopyIndex !== cntCopy[3:0]) begin
            idxBad <= idxBad + 8'h01;
        end
        if (rxBytePush === 1'b1) begin
            rxQ.push_back(rxByte);
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            numErrors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("Mismatches %0d, compares %0d", numErrors, compares);
        if (numErrors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic settle;
        repeat (3) @(negedge core_clk);
    endtask

    // Kind 0 starts a frame, 1 delivers a bit, 2 ends the frame.
    task automatic rx(input int kind, input logic b);
        @(negedge core_clk);
        rxFrameStart = (kind == 0);
        rxBitValid = (kind == 1);
        rxFrameEnd = (kind == 2);
        rxBitIn = b;
        @(negedge core_clk);
        rxFrameStart = 1'b0;
        rxBitValid = 1'b0;
        rxFrameEnd = 1'b0;
        rxBitIn = ~b;
    endtask

    // Main sequence: reset values, strobes, copy, levels, framing, send.
    initial begin
        logic [7:0] d;
        logic [7:0] pat;
        rst_n = 1'b0;
        rxFrameStart = 1'b0;
        rxBitValid = 1'b0;
        rxBitIn = 1'b0;
        rxFrameEnd = 1'b0;
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        check({7'h00, fifoNearEmptyFlag}, 8'h01);
        check({7'h00, fifoNearFullFlag}, 8'h00);
        host.rd(OFF_WARN, d);
        check(d, 8'h08);
        host.rd(OFF_CTRL, d);
        check(d, 8'h00);
        host.rd(OFF_FRAMING, d);
        check(d, 8'h00);
        host.rd(6'h3f, d);
        check(d, 8'h00);
        host.wr(OFF_WARN, 8'hff);
        host.rd(OFF_WARN, d);
        check(d, 8'h3f);
        host.wr(OFF_WARN, 8'h03);
        host.wr(OFF_CTRL, 8'h80);
        settle;
        check(cntStop, 8'h01);
        check(cntStart, 8'h00);
        host.wr(OFF_CTRL, 8'h50);
        settle;
        check(cntStart, 8'h01);
        check({7'h00, initiatorMode}, 8'h01);
        host.rd(OFF_CTRL, d);
        check(d, 8'h10);
        host.wr(OFF_CTRL, 8'h00);
        settle;
        check({7'h00, initiatorMode}, 8'h00);
        host.wr(OFF_CTRL, 8'h20);
        host.rd(OFF_CTRL, d);
        check(d & 8'h20, 8'h20);
        repeat (16) @(negedge core_clk);
        check(cntCopy, 8'h0a);
        check(idxBad, 8'h00);
        check({1'b0, fifoFillCount}, 8'h0a);
        host.rd(OFF_CTRL, d);
        check(d, 8'h00);
        repeat (6) host.rd(OFF_FIFO_DATA, d);
        settle;
        check({1'b0, fifoFillCount}, 8'h04);
        check({7'h00, fifoNearEmptyFlag}, 8'h00);
        host.rd(OFF_FIFO_DATA, d);
        settle;
        check({7'h00, fifoNearEmptyFlag}, 8'h01);
        host.wr(OFF_WARN, 8'h3c);
        settle;
        check({7'h00, fifoNearFullFlag}, 8'h00);
        host.wr(OFF_WARN, 8'h3d);
        settle;
        check({7'h00, fifoNearFullFlag}, 8'h01);
        host.wr(OFF_FIFO_DATA, 8'h5a);
        settle;
        check({1'b0, fifoFillCount}, 8'h04);
        host.wr(OFF_FIFO_LEVEL, 8'h80);
        settle;
        check({1'b0, fifoFillCount}, 8'h00);
        check(cntFlush, 8'h01);
        // Alignment 7: first bit at the top, the rest wrap into a new byte.
        host.wr(OFF_FRAMING, 8'h70);
        rx(0, 1'b0);
        rx(1, 1'b1);
        rx(1, 1'b1);
        rx(1, 1'b0);
        rx(1, 1'b1);
        rx(2, 1'b0);
        settle;
        check(8'(rxQ.size()), 8'h02);
        check(rxQ[0], 8'h80);
        check(rxQ[1] & 8'h07, 8'h05);
        host.rd(OFF_CTRL, d);
        check(d & 8'h07, 8'h03);
        host.wr(OFF_FRAMING, 8'h00);
        rxQ.delete();
        pat = 8'ha5;
        rx(0, 1'b0);
        for (int i = 0; i < 8; i++) rx(1, pat[i]);
        rx(2, 1'b0);
        settle;
        check(8'(rxQ.size()), 8'h01);
        check(rxQ[0], pat);
        host.rd(OFF_CTRL, d);
        check(d & 8'h07, 8'h00);
        // Start strobe outside the waiting state is refused.
        host.wr(OFF_FRAMING, 8'h85);
        settle;
        check(cntTx, 8'h00);
        check({5'h00, txFinalBitCount}, 8'h05);
        host.rd(OFF_FRAMING, d);
        check(d, 8'h05);
        host.wr(OFF_FRAMING, 8'h00);
        settle;
        check({5'h00, txFinalBitCount}, 8'h00);
        host.transceive(1'b1);
        for (int i = 0; i < 20 && modemState !== MODEM_WAIT_SEND; i++) begin
            @(negedge core_clk);
        end
        // A wait that runs out counts as a mismatch and skips to the verdict.
        if (modemState !== MODEM_WAIT_SEND) begin
            numErrors++;
        end else begin
            check({5'h00, modemState}, 8'h01);
            host.wr(OFF_FRAMING, 8'h80);
            settle;
            check(cntTx, 8'h01);
            check({5'h00, modemState}, 8'h03);
            host.wr(OFF_FRAMING, 8'h00);
            settle;
            check({5'h00, modemState}, 8'h03);
            host.transceive(1'b0);
            settle;
            check({5'h00, modemState}, 8'h00);
        end
        print_verdict;
    end
endmodule
`default_nettype wire
